/* File: design/cid_serial_out.sv */
// caller id serial output port, fsk slicer, ring detect and interrupt
// Operation
// RULE1: a low mode select runs the port device-clocked and a high one host-clocked.
// RULE2: device-clocked, the device starts each transfer; clock and data follow the tones.
// RULE3: host-clocked, the host pulls each byte out by driving the shift clock.
// RULE4: host-clocked, the device flags the host once a whole byte is held for reading.
// RULE5: the slicer recovers keyed serial data at 1200 baud.
// RULE6: ring logic reacts to a line reversal, a short burst and normal ringing.
// RULE7: the active low ring output asserts whenever reversal or ringing is seen.
// RULE8: after ring activity ends the ring output holds until the timing node passes threshold.
// RULE9: an output flag shows that a keyed carrier is present.
// RULE10: the device drives the shift clock pin device-clocked, the host host-clocked.
// RULE11: host-clocked, each bit appears on the rising shift clock edge, mark one and space zero.
// RULE12: byte ready marks byte boundaries device-clocked and flags a held byte host-clocked.
// RULE13: the open drain interrupt pulls low while ring, byte ready or alert is active.
// RULE14: host-clocked, byte ready clears after eight shift clock pulses from the host.
module cid_serial_out
   import cid_pkg::*;
#(
   parameter logic [cid_pkg::CNT_W-1:0] BIT_CYC = 17'(cid_pkg::BIT_CYC_DEF),
   parameter logic [cid_pkg::CNT_W-1:0] SPLIT_HALF = 17'(cid_pkg::SPLIT_HALF_DEF),
   parameter logic [cid_pkg::CNT_W-1:0] MIN_HALF = 17'(cid_pkg::MIN_HALF_DEF),
   parameter logic [cid_pkg::CNT_W-1:0] MAX_HALF = 17'(cid_pkg::MAX_HALF_DEF)
) (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic SERIAL_SHIFT_CLOCK_I,
   input wire logic MODE_SEL,
   input wire logic FSK_IN,
   input wire logic FSK_ENABLE,
   input wire logic RING_SENSE_IN,
   input wire logic RING_HOLD_TIMING_NODE_I,
   input wire logic ALERT_TONE_QUALIFIED,
   output logic SERIAL_SHIFT_CLOCK_O,
   output logic SERIAL_SHIFT_CLOCK_OE,
   output logic DATA_OUT,
   output logic BYTE_READY_N,
   output logic CARRIER_DETECT_N,
   output logic RING_DETECT_OUT_N,
   output logic RING_HOLD_TIMING_NODE_O,
   output logic RING_HOLD_TIMING_NODE_OE,
   output logic HOST_IRQ_N_O,
   output logic HOST_IRQ_N_OE
);
   import cid_pkg::*;

   localparam logic [CNT_W-1:0] HALF_BIT = BIT_CYC >> 1;

   pins_s ps;
   demod_s dm_r, dm_nxt;
   logic tgl_l_r, tgl_l_nxt;
   logic fsk_prev_r, done_prev_r, ring_prev_r;
   logic [CNT_W-1:0] hc_r, hc_nxt, bt_r, bt_nxt;
   logic [3:0] good_r, good_nxt;
   rx_state_e st_r, st_nxt;
   logic [2:0] n_r, n_nxt;
   logic [7:0] sh_r, sh_nxt, hold_r, hold_nxt;
   logic byte_done, done_evt, ring_act;
   logic sclk_r, sclk_nxt, sclk_oe_r, sclk_oe_nxt, data_d_r, data_d_nxt;
   logic rdy_n_r, rdy_n_nxt, cd_n_r, cd_n_nxt;
   logic ring_n_r, ring_n_nxt, irq_oe_r, irq_oe_nxt;
   logic [5:0] dis_r, dis_nxt;
   logic node_oe_r, node_oe_nxt;
   logic [2:0] cnt_l_r, cnt_l_nxt;
   logic bit_l_r, bit_l_nxt;

   // all input pins but the shift clock and reset, plus the link toggle, cross through one synchroniser bank
   pin_sync3 #(.W(SYNC_W)) u_sync (
      .clk(REF_CLK),
      .nrst(NRST),
      .d({tgl_l_r, ALERT_TONE_QUALIFIED, RING_HOLD_TIMING_NODE_I, RING_SENSE_IN,
          FSK_ENABLE, FSK_IN, MODE_SEL}),
      .q(ps)
   );

   function automatic logic in_window(input logic [CNT_W-1:0] c);
      in_window = (c >= MIN_HALF) && (c <= MAX_HALF);
   endfunction : in_window

   // tone slicer: half period length picks mark or space
   always_comb begin
      hc_nxt = (hc_r == MAX_HALF) ? hc_r : hc_r + 17'h0_0001;
      good_nxt = good_r;
      dm_nxt = dm_r;
      if (ps.fsk != fsk_prev_r) begin
         hc_nxt = '0;
         dm_nxt.bit_val = (hc_r >= SPLIT_HALF); // RULE5
         if (!in_window(hc_r)) begin
            good_nxt = '0;
         end else if (good_r != CD_QUAL_EDGES) begin
            good_nxt = good_r + 4'h1;
         end
      end else if (hc_r == MAX_HALF) begin
         good_nxt = '0; // tones gone too long
      end
      dm_nxt.carrier = (good_nxt == CD_QUAL_EDGES); // RULE9
      if (!ps.fsk_en) begin
         dm_nxt = '{carrier: 1'b0, bit_val: 1'b1};
         good_nxt = '0;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         hc_r <= '0;
         good_r <= '0;
         dm_r <= '{carrier: 1'b0, bit_val: 1'b1};
         fsk_prev_r <= 1'b0;
      end else begin
         hc_r <= hc_nxt;
         good_r <= good_nxt;
         dm_r <= dm_nxt;
         fsk_prev_r <= ps.fsk;
      end
   end

   // async framing: start, eight data bits lsb first, stop
   always_comb begin
      st_nxt = st_r;
      bt_nxt = (bt_r == '0) ? bt_r : bt_r - 17'h0_0001;
      n_nxt = n_r;
      sh_nxt = sh_r;
      byte_done = 1'b0;
      unique case (st_r)
         RX_IDLE: begin
            if (dm_r.carrier && !dm_r.bit_val) begin
               st_nxt = RX_START; // RULE5
               bt_nxt = HALF_BIT;
            end
         end
         RX_START: begin
            if (bt_r == '0) begin
               st_nxt = dm_r.bit_val ? RX_IDLE : RX_DATA;
               bt_nxt = BIT_CYC;
               n_nxt = '0;
            end
         end
         RX_DATA: begin
            if (bt_r == '0) begin
               sh_nxt = {dm_r.bit_val, sh_r[7:1]};
               bt_nxt = BIT_CYC;
               n_nxt = n_r + 3'h1;
               if (n_r == LAST_BIT) begin
                  st_nxt = RX_STOP;
                  byte_done = 1'b1;
               end
            end
         end
         RX_STOP: begin
            if (bt_r == '0) begin
               st_nxt = RX_IDLE;
            end
         end
      endcase
      if (!dm_r.carrier) begin
         st_nxt = RX_IDLE; // a lost carrier drops a partly received byte
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         st_r <= RX_IDLE;
         bt_r <= '0;
         n_r <= '0;
         sh_r <= BYTE_RST;
      end else begin
         st_r <= st_nxt;
         bt_r <= bt_nxt;
         n_r <= n_nxt;
         sh_r <= sh_nxt;
      end
   end

   assign done_evt = (ps.done_tgl != done_prev_r);

   // output port: device clocked pulses, host clocked byte hand over
   always_comb begin
      sclk_oe_nxt = !ps.mode; // RULE10
      sclk_nxt = !ps.mode && bt_r > HALF_BIT
         && ((st_r == RX_DATA && n_r != '0) || st_r == RX_STOP); // RULE2
      data_d_nxt = dm_r.bit_val; // RULE2
      hold_nxt = hold_r;
      rdy_n_nxt = rdy_n_r;
      if (!ps.mode) begin
         rdy_n_nxt = (st_r != RX_STOP); // RULE12
      end else begin
         if (done_evt) begin
            rdy_n_nxt = 1'b1; // RULE14
         end
         if (byte_done && (rdy_n_r || done_evt)) begin
            hold_nxt = sh_nxt;
            rdy_n_nxt = 1'b0; // RULE4
         end
      end
      cd_n_nxt = !dm_r.carrier; // RULE9
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         sclk_oe_r <= 1'b1;
         sclk_r <= 1'b0;
         data_d_r <= 1'b1;
         hold_r <= BYTE_RST;
         rdy_n_r <= 1'b1;
         cd_n_r <= 1'b1;
         done_prev_r <= 1'b0;
      end else begin
         sclk_oe_r <= sclk_oe_nxt;
         sclk_r <= sclk_nxt;
         data_d_r <= data_d_nxt;
         hold_r <= hold_nxt;
         rdy_n_r <= rdy_n_nxt;
         cd_n_r <= cd_n_nxt;
         done_prev_r <= ps.done_tgl;
      end
   end

   // link side: hold_r stays put while ready, so it is read quasi-static here
   always_comb begin
      bit_l_nxt = hold_r[cnt_l_r]; // RULE11
      cnt_l_nxt = cnt_l_r + 3'h1;
      tgl_l_nxt = (cnt_l_r == LAST_BIT) ? !tgl_l_r : tgl_l_r; // RULE14
   end

   always_ff @(posedge SERIAL_SHIFT_CLOCK_I or negedge NRST) begin
      if (!NRST) begin
         cnt_l_r <= '0;
         bit_l_r <= 1'b1;
         tgl_l_r <= 1'b0;
      end else begin
         cnt_l_r <= cnt_l_nxt;
         bit_l_r <= bit_l_nxt;
         tgl_l_r <= tgl_l_nxt;
      end
   end

   // ring: any edge on the sense input counts, so reversal and bursts both hit
   assign ring_act = (ps.ring != ring_prev_r); // RULE6
   always_comb begin
      dis_nxt = ring_act ? RING_DISCH_CYC : ((dis_r == '0) ? dis_r : dis_r - 6'h01);
      node_oe_nxt = (dis_nxt != '0); // RULE8
      ring_n_nxt = ring_n_r;
      if (ring_act) begin
         ring_n_nxt = 1'b0; // RULE7
      end else if (dis_r == '0 && ps.node_hi) begin
         ring_n_nxt = 1'b1; // RULE8
      end
      irq_oe_nxt = !ring_n_r || !rdy_n_r || ps.alert; // RULE13
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         dis_r <= '0;
         node_oe_r <= 1'b0;
         ring_n_r <= 1'b1;
         irq_oe_r <= 1'b0;
         ring_prev_r <= 1'b0;
      end else begin
         dis_r <= dis_nxt;
         node_oe_r <= node_oe_nxt;
         ring_n_r <= ring_n_nxt;
         irq_oe_r <= irq_oe_nxt;
         ring_prev_r <= ps.ring;
      end
   end

   assign SERIAL_SHIFT_CLOCK_O = sclk_r;
   assign SERIAL_SHIFT_CLOCK_OE = sclk_oe_r;
   // mux of two flops, one per domain; mode is static during a byte
   assign DATA_OUT = ps.mode ? bit_l_r : data_d_r; // RULE1
   assign BYTE_READY_N = rdy_n_r;
   assign CARRIER_DETECT_N = cd_n_r;
   assign RING_DETECT_OUT_N = ring_n_r;
   assign RING_HOLD_TIMING_NODE_O = 1'b0;
   assign RING_HOLD_TIMING_NODE_OE = node_oe_r;
   assign HOST_IRQ_N_O = 1'b0;
   assign HOST_IRQ_N_OE = irq_oe_r;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   sequence s_start_seen;
      st_r == RX_IDLE && dm_r.carrier && !dm_r.bit_val;
   endsequence
   sequence s_start_taken;
      st_r == RX_START && bt_r == HALF_BIT;
   endsequence

   a_mode_host_pin: assert property ( // RULE1
      ps.mode && $past(ps.mode) |-> !SERIAL_SHIFT_CLOCK_OE && !SERIAL_SHIFT_CLOCK_O)
      else $error("shift clock driven in host mode");
   a_dev_clk_src: assert property ( // RULE2
      $rose(SERIAL_SHIFT_CLOCK_O) |-> SERIAL_SHIFT_CLOCK_OE
         && (st_r == RX_DATA || st_r == RX_STOP))
      else $error("device clock pulse outside a byte");
   a_host_flag_set: assert property ( // RULE4
      ps.mode && byte_done && BYTE_READY_N |=> !BYTE_READY_N && hold_r == $past(sh_nxt))
      else $error("byte ready not raised");
   a_start_detect: assert property ( // RULE5
      s_start_seen ##1 dm_r.carrier |-> s_start_taken)
      else $error("start bit missed");
   a_ring_node_pull: assert property ( // RULE8
      ring_act |=> RING_HOLD_TIMING_NODE_OE [*8])
      else $error("timing node not discharged");
   a_ring_assert: assert property ( // RULE7
      ring_act |=> !RING_DETECT_OUT_N)
      else $error("ring output not asserted");
   a_ring_hold_low: assert property ( // RULE8
      !RING_DETECT_OUT_N && (dis_r != '0 || !ps.node_hi) |=> !RING_DETECT_OUT_N)
      else $error("ring output released early");
   // disabled slicer or a silent line must drop the flag two edges on
   a_carrier_drop: assert property ( // RULE9
      (!ps.fsk_en || (hc_r == MAX_HALF && ps.fsk == fsk_prev_r)) |-> ##2 CARRIER_DETECT_N)
      else $error("carrier flag stuck");
   a_dir_follow: assert property ( // RULE10
      $stable(ps.mode) |=> SERIAL_SHIFT_CLOCK_OE == !$past(ps.mode))
      else $error("shift clock direction wrong");
   a_boundary_mark: assert property ( // RULE12
      !ps.mode && st_r == RX_STOP |=> !BYTE_READY_N)
      else $error("byte boundary not marked");
   a_irq_sources: assert property ( // RULE13
      (!RING_DETECT_OUT_N || !BYTE_READY_N) |=> HOST_IRQ_N_OE)
      else $error("interrupt not pulled low");
   a_irq_release: assert property ( // RULE13
      !ps.alert && RING_DETECT_OUT_N && BYTE_READY_N |=> !HOST_IRQ_N_OE)
      else $error("interrupt not released");
   a_host_clear: assert property (ps.mode && done_evt && !byte_done |=> BYTE_READY_N) // RULE14
      else $error("byte ready not cleared");
   a_link_wrap: assert property (@(posedge SERIAL_SHIFT_CLOCK_I) disable iff (!NRST)
      cnt_l_r == LAST_BIT |=> cnt_l_r == '0 && tgl_l_r != $past(tgl_l_r)) // RULE11
      else $error("link bit count wrap wrong");
endmodule : cid_serial_out

/* File: design/cid_pkg.sv */
// shared constants and types for the caller id output block
package cid_pkg;
   // clock and line signalling rates
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_RATE = 1200;
   localparam int MARK_HZ = 1200;
   localparam int SPACE_HZ = 2200;
   localparam int SPLIT_HZ = 1700;
   localparam int CARRIER_MIN_HZ = 1000;
   localparam int CARRIER_MAX_HZ = 2600;
   localparam int CNT_W = 17;
   // default cycle counts, derived from the rates above
   localparam int BIT_CYC_DEF = CLK_HZ / BAUD_RATE;
   localparam int SPLIT_HALF_DEF = CLK_HZ / (2 * SPLIT_HZ);
   localparam int MIN_HALF_DEF = CLK_HZ / (2 * CARRIER_MAX_HZ);
   localparam int MAX_HALF_DEF = CLK_HZ / (2 * CARRIER_MIN_HZ);
   // good edges in a row before carrier is declared
   localparam logic [3:0] CD_QUAL_EDGES = 4'h8;
   // cycles the ring timing node is pulled low after activity
   localparam logic [5:0] RING_DISCH_CYC = 6'h20;
   localparam int SYNC_W = 7;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // receiver framing, gray coded along idle-start-data-stop
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b11,
      RX_STOP = 2'b10
   } rx_state_e;
   // synchronised pin levels
   typedef struct packed {
      logic done_tgl;
      logic alert;
      logic node_hi;
      logic ring;
      logic fsk_en;
      logic fsk;
      logic mode;
   } pins_s;
   // demodulator status
   typedef struct packed {
      logic carrier;
      logic bit_val;
   } demod_s;
endpackage : cid_pkg

/* File: design/pin_sync3.sv */
// three flop synchroniser that accepts a change once stages two and three agree
module pin_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

   // stage one feeds only stage two
   always_comb begin
      q_nxt = q_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   // registers only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : pin_sync3

/* File: test/host_model.sv */
// host side model that pulls each held byte out over the shift clock
module host_model (
   input wire logic byte_ready_n,
   input wire logic data_out,
   input wire logic mode,
   output logic sclk,
   output logic [7:0] got,
   output logic got_tgl
);
   timeunit 1ns;
   timeprecision 1ns;
   integer i;
   // clock stands low between bytes and runs at 48 ns only inside a frame
   initial begin
      sclk = 1'b0;
      got = 8'h00;
      got_tgl = 1'b0;
      forever begin
         wait (mode && byte_ready_n === 1'b0);
         #100;
         // exactly eight clocks a byte, the link bit counter is free running
         for (i = 0; i < 8; i++) begin
            #24 sclk = 1'b1;
            #2 got[i] = data_out;
            #22 sclk = 1'b0;
         end
         got_tgl = ~got_tgl;
         wait (byte_ready_n === 1'b1);
      end
   end
endmodule : host_model

/* File: test/tb_top.sv */
// self-checking bench for the caller id serial output block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic mode = 1'b0;
   logic fsk = 1'b0;
   logic fsk_en = 1'b1;
   logic ring = 1'b0;
   logic alert = 1'b0;
   logic sclk_o, sclk_oe, data, rdy_n, cd_n, ring_n, node_o, node_oe, irq_o, irq_oe;
   logic host_sclk, sclk_d, got_tgl, t;
   logic [7:0] m0, got;
   wire sck = sclk_oe ? sclk_o : host_sclk;
   int err_total = 0;
   int cmp_count = 0;
   int rdy_cnt = 0;
   int ncnt = 0;
   int n0, k, r;
   wire node_i = node_oe ? 1'b0 : (ncnt == 100);
   // {mode, byte sent, byte expected}
   logic [16:0] rows [6] = '{17'h0_a5a5, 17'h0_ffff, 17'h0_0000, 17'h1_3c3c,
      17'h1_8080, 17'h1_0101};

   always #5 clk = ~clk;

   cid_serial_out #(.BIT_CYC(17'h0_00c8), .SPLIT_HALF(17'h0_0023), .MIN_HALF(17'h0_000f),
      .MAX_HALF(17'h0_003c)) dut (.REF_CLK(clk), .NRST(nrst), .SERIAL_SHIFT_CLOCK_I(sck),
      .MODE_SEL(mode), .FSK_IN(fsk), .FSK_ENABLE(fsk_en), .RING_SENSE_IN(ring),
      .RING_HOLD_TIMING_NODE_I(node_i), .ALERT_TONE_QUALIFIED(alert),
      .SERIAL_SHIFT_CLOCK_O(sclk_o), .SERIAL_SHIFT_CLOCK_OE(sclk_oe), .DATA_OUT(data),
      .BYTE_READY_N(rdy_n), .CARRIER_DETECT_N(cd_n), .RING_DETECT_OUT_N(ring_n),
      .RING_HOLD_TIMING_NODE_O(node_o), .RING_HOLD_TIMING_NODE_OE(node_oe),
      .HOST_IRQ_N_O(irq_o), .HOST_IRQ_N_OE(irq_oe));

   host_model host (.byte_ready_n(rdy_n), .data_out(data), .mode(mode), .sclk(host_sclk),
      .got(got), .got_tgl(got_tgl));

   // rc node charges 100 cycles after the pull-down lets go
   always @(posedge clk) begin
      if (node_oe)
         ncnt <= 0;
      else if (ncnt < 100)
         ncnt <= ncnt + 1;
   end

   // device clocked capture on each rising shift clock, lsb first
   always @(posedge clk) begin
      if (!mode && sclk_o && !sclk_d)
         m0 <= {data, m0[7:1]};
      sclk_d <= sclk_o;
   end

   always @(negedge rdy_n) rdy_cnt++;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("mismatches %0d of %0d checks", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   // keyed tone, mark half period 50 cycles and space 25
   task automatic tone(input logic b, input int cyc);
      int n;
      n = 0;
      while (n < cyc) begin
         repeat (b ? 50 : 25) @(posedge clk);
         fsk <= ~fsk;
         n += b ? 50 : 25;
      end
   endtask : tone

   // start bit, eight data bits lsb first, stop bit
   task automatic send_byte(input logic [7:0] b);
      tone(1'b0, 200);
      for (int i = 0; i < 8; i++)
         tone(b[i], 200);
      tone(1'b1, 200);
   endtask : send_byte

   // t is taken before the byte is sent, the host may finish before this runs
   task automatic take_byte(input logic [7:0] exp);
      for (k = 0; k < 3000 && got_tgl === t; k++)
         @(posedge clk);
      chk(got_tgl, !t);
      chk(got, exp);
      repeat (12) @(posedge clk);
      chk(rdy_n, 1'b1);
   endtask : take_byte

   initial begin
      #400_000;
      err_total++;
      end_of_test();
   end

   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (r = 0; r < 6; r++) begin
         mode <= rows[r][16];
         repeat (10) @(posedge clk);
         chk(sclk_oe, !rows[r][16]);
         tone(1'b1, 800);
         chk(cd_n, 1'b0);
         n0 = rdy_cnt;
         t = got_tgl;
         send_byte(rows[r][15:8]);
         tone(1'b1, 200);
         chk(rdy_cnt, n0 + 1);
         if (rows[r][16])
            take_byte(rows[r][7:0]);
         else
            chk(m0, rows[r][7:0]);
         repeat (100) @(posedge clk);
         chk(cd_n, 1'b1);
      end
      // back to back bytes, host clocked
      tone(1'b1, 800);
      send_byte(8'h5a);
      chk(got, 8'h5a);
      t = got_tgl;
      send_byte(8'hc3);
      take_byte(8'hc3);
      // carrier forced off while tones still run
      tone(1'b1, 400);
      fsk_en <= 1'b0;
      tone(1'b1, 100);
      chk(cd_n, 1'b1);
      fsk_en <= 1'b1;
      mode <= 1'b0;
      repeat (100) @(posedge clk);
      // mid-run reset
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({rdy_n, cd_n, ring_n, irq_oe}, 4'he);
      nrst <= 1'b1;
      repeat (150) @(posedge clk);
      // single reversal, then a short burst
      for (k = 0; k < 2; k++) begin
         ring <= ~ring;
         if (k == 1) begin
            repeat (10) @(posedge clk);
            ring <= ~ring;
         end
         repeat (8) @(posedge clk);
         chk({ring_n, irq_oe}, 2'h1);
         chk({node_o, irq_o}, 2'h0);
         repeat (60) @(posedge clk);
         chk(ring_n, 1'b0);
         repeat (200) @(posedge clk);
         chk({ring_n, irq_oe}, 2'h2);
      end
      alert <= 1'b1;
      repeat (8) @(posedge clk);
      chk(irq_oe, 1'b1);
      alert <= 1'b0;
      repeat (8) @(posedge clk);
      chk(irq_oe, 1'b0);
      end_of_test();
   end
endmodule : tb_top
